// File: hw/motor_pwm_engine_defs.vh
`ifndef MOTOR_PWM_ENGINE_DEFS_VH
`define MOTOR_PWM_ENGINE_DEFS_VH

// carrier shape codes on i_carrier_shape_select
`define SHAPE_UP        2'h0
`define SHAPE_DOWN      2'h1
`define SHAPE_UPDOWN    2'h2

// per-output drive codes used in the commutation tables
`define DRV_LOW         2'h0
`define DRV_HIGH        2'h1
`define DRV_PWM         2'h2
`define DRV_PWMB        2'h3

// hall codes
`define HALL_000        3'h0
`define HALL_001        3'h1
`define HALL_010        3'h2
`define HALL_011        3'h3
`define HALL_100        3'h4
`define HALL_101        3'h5
`define HALL_110        3'h6
`define HALL_111        3'h7

// table geometry
`define TBL_ENTRIES     16
`define TBL_ALL_LOW     12'h000
`define GATE_ALL_LOW    6'h00

// counter constants
`define CNT_ZERO        11'h000
`define CNT_ONE         11'h001
`define PRE_ZERO        2'h0
`define PRE_ONE         2'h1
`define POST_ZERO       3'h0
`define POST_ONE        3'h1

`endif

// File: hw/motor_pwm_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "motor_pwm_engine_defs.vh"

module motor_pwm_engine (
    input  wire        i_mclk,                // system clock, 250 MHz
    input  wire        i_arst_n,              // async reset, active low
    input  wire [1:0]  i_carrier_shape_select,// carrier shape code
    input  wire [1:0]  i_carrier_prescale,    // prescale factor, 0 acts as 1
    input  wire [2:0]  i_carrier_postscale,   // postscale factor, 0 acts as 1
    input  wire [10:0] i_carrier_period,      // carrier period in ticks
    input  wire [7:0]  i_duty_high_reg,       // duty upper 8 bits
    input  wire [2:0]  i_duty_low_ext_reg,    // duty lower 3 bits
    input  wire [2:0]  i_hall_pins,           // hall sensor pins, async
    input  wire [2:0]  i_hall_soft,           // software hall code
    input  wire        i_hall_pin_mode,       // 1: hall from pins
    input  wire        i_rotation_direction,  // commutation direction
    input  wire        i_user_table_en,       // 1: use user table
    input  wire        i_user_table_wr,       // user table write strobe
    input  wire [3:0]  i_user_table_addr,     // {direction, hall}
    input  wire [11:0] i_user_table_data,     // six 2-bit drive codes
    input  wire        i_sine_select,         // 1: drive from sine path
    input  wire [5:0]  i_sine_gates,          // sine path gates {u,v,w,x,y,z}
    output reg  [10:0] o_carrier,             // carrier count
    output reg         o_pwm,                 // compared pwm
    output reg         o_gate_u,              // upper u gate
    output reg         o_gate_v,              // upper v gate
    output reg         o_gate_w,              // upper w gate
    output reg         o_gate_x,              // lower x gate
    output reg         o_gate_y,              // lower y gate
    output reg         o_gate_z               // lower z gate
);

    // reset synchroniser
    reg         rst_meta;                     // first stage
    reg         rst_sync_n;                   // released reset copy

    // hall synchroniser
    reg  [2:0]  hall_meta;                    // first stage, read only by next
    reg  [2:0]  hall_sync;                    // synchronised hall pins

    // carrier state
    reg  [1:0]  pre_cnt;                      // prescale counter
    reg  [2:0]  post_cnt;                     // postscale counter
    reg  [10:0] carrier;                      // carrier counter
    reg         count_down;                   // up-down phase flag
    reg  [1:0]  next_pre_cnt;
    reg  [2:0]  next_post_cnt;
    reg  [10:0] next_carrier;
    reg         next_count_down;

    // commutation
    reg  [11:0] user_table [0:`TBL_ENTRIES-1]; // user patterns
    reg  [11:0] pattern;                      // selected pattern
    reg  [5:0]  next_gate;                    // muxed gate vector
    wire [2:0]  hall_code;                    // active hall code
    wire [10:0] duty;                         // assembled duty
    wire [1:0]  pre_lim;                      // effective prescale
    wire [2:0]  post_lim;                     // effective postscale
    wire        tick;                         // carrier advance strobe
    integer     k;

    // zero factors act as one so the carrier never stalls
    assign pre_lim  = (i_carrier_prescale  == `PRE_ZERO)  ? `PRE_ONE  : i_carrier_prescale;
    assign post_lim = (i_carrier_postscale == `POST_ZERO) ? `POST_ONE : i_carrier_postscale;
    assign tick     = (pre_cnt == pre_lim - `PRE_ONE) && (post_cnt == post_lim - `POST_ONE);
    assign duty     = {i_duty_high_reg, i_duty_low_ext_reg};
    assign hall_code = i_hall_pin_mode ? hall_sync : i_hall_soft;

    // default commutation pattern, codes ordered u v w x y z
    function [11:0] default_pattern;
        input       dir;
        input [2:0] hall;
        begin
            default_pattern = `TBL_ALL_LOW;
            if (!dir) begin
                case (hall)
                    `HALL_001: default_pattern = {`DRV_PWM, `DRV_LOW, `DRV_LOW,
                                                  `DRV_PWMB, `DRV_HIGH, `DRV_LOW};
                    `HALL_011: default_pattern = {`DRV_LOW, `DRV_LOW, `DRV_PWM,
                                                  `DRV_LOW, `DRV_HIGH, `DRV_PWMB};
                    `HALL_010: default_pattern = {`DRV_LOW, `DRV_LOW, `DRV_PWM,
                                                  `DRV_HIGH, `DRV_LOW, `DRV_PWMB};
                    `HALL_110: default_pattern = {`DRV_LOW, `DRV_PWM, `DRV_LOW,
                                                  `DRV_HIGH, `DRV_PWMB, `DRV_LOW};
                    `HALL_100: default_pattern = {`DRV_LOW, `DRV_PWM, `DRV_LOW,
                                                  `DRV_LOW, `DRV_PWMB, `DRV_HIGH};
                    `HALL_101: default_pattern = {`DRV_PWM, `DRV_LOW, `DRV_LOW,
                                                  `DRV_PWMB, `DRV_LOW, `DRV_HIGH};
                    default:   default_pattern = `TBL_ALL_LOW;
                endcase
            end else begin
                case (hall)
                    `HALL_101: default_pattern = {`DRV_LOW, `DRV_LOW, `DRV_PWM,
                                                  `DRV_HIGH, `DRV_LOW, `DRV_PWMB};
                    `HALL_100: default_pattern = {`DRV_LOW, `DRV_LOW, `DRV_PWM,
                                                  `DRV_LOW, `DRV_HIGH, `DRV_PWMB};
                    `HALL_110: default_pattern = {`DRV_PWM, `DRV_LOW, `DRV_LOW,
                                                  `DRV_PWMB, `DRV_HIGH, `DRV_LOW};
                    `HALL_010: default_pattern = {`DRV_PWM, `DRV_LOW, `DRV_LOW,
                                                  `DRV_PWMB, `DRV_LOW, `DRV_HIGH};
                    `HALL_011: default_pattern = {`DRV_LOW, `DRV_PWM, `DRV_LOW,
                                                  `DRV_LOW, `DRV_PWMB, `DRV_HIGH};
                    `HALL_001: default_pattern = {`DRV_LOW, `DRV_PWM, `DRV_LOW,
                                                  `DRV_HIGH, `DRV_PWMB, `DRV_LOW};
                    default:   default_pattern = `TBL_ALL_LOW;
                endcase
            end
        end
    endfunction

    // turn one 2-bit drive code into a gate level
    function resolve;
        input [1:0] code;
        input       pwm;
        begin
            case (code)
                `DRV_LOW:  resolve = 1'b0;
                `DRV_HIGH: resolve = 1'b1;
                `DRV_PWM:  resolve = pwm;
                default:   resolve = ~pwm;
            endcase
        end
    endfunction

    // reset release through two flops
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // hall pins cross into the clock domain
    always @(posedge i_mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hall_meta <= `HALL_000;
            hall_sync <= `HALL_000;
        end else begin
            hall_meta <= i_hall_pins;
            hall_sync <= hall_meta;
        end
    end

    // carrier next state: divider then shaped counter
    always @* begin
        next_pre_cnt    = pre_cnt + `PRE_ONE;
        next_post_cnt   = post_cnt;
        next_carrier    = carrier;
        next_count_down = count_down;
        // prescale wraps, postscale counts prescale wraps
        if (pre_cnt >= pre_lim - `PRE_ONE) begin
            next_pre_cnt  = `PRE_ZERO;
            next_post_cnt = post_cnt + `POST_ONE;
            if (post_cnt >= post_lim - `POST_ONE) begin
                next_post_cnt = `POST_ZERO;
            end
        end
        if (i_carrier_period == `CNT_ZERO) begin
            // no period: park the carrier
            next_carrier    = `CNT_ZERO;
            next_count_down = 1'b0;
        end else if (tick) begin
            case (i_carrier_shape_select)
                `SHAPE_UP: begin
                    next_count_down = 1'b0;
                    if (carrier >= i_carrier_period - `CNT_ONE) begin
                        next_carrier = `CNT_ZERO;
                    end else begin
                        next_carrier = carrier + `CNT_ONE;
                    end
                end
                `SHAPE_DOWN: begin
                    next_count_down = 1'b1;
                    if (carrier == `CNT_ZERO || carrier >= i_carrier_period) begin
                        next_carrier = i_carrier_period - `CNT_ONE;
                    end else begin
                        next_carrier = carrier - `CNT_ONE;
                    end
                end
                default: begin
                    // period ticks up to the peak, period ticks back down
                    if (!count_down) begin
                        if (carrier >= i_carrier_period - `CNT_ONE) begin
                            next_carrier    = i_carrier_period;
                            next_count_down = 1'b1;
                        end else begin
                            next_carrier = carrier + `CNT_ONE;
                        end
                    end else begin
                        if (carrier <= `CNT_ONE || carrier > i_carrier_period) begin
                            next_carrier    = `CNT_ZERO;
                            next_count_down = 1'b0;
                        end else begin
                            next_carrier = carrier - `CNT_ONE;
                        end
                    end
                end
            endcase
        end
    end

    // carrier registers
    always @(posedge i_mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pre_cnt    <= `PRE_ZERO;
            post_cnt   <= `POST_ZERO;
            carrier    <= `CNT_ZERO;
            count_down <= 1'b0;
        end else begin
            pre_cnt    <= next_pre_cnt;
            post_cnt   <= next_post_cnt;
            carrier    <= next_carrier;
            count_down <= next_count_down;
        end
    end

    // user table storage, written one entry per strobe
    always @(posedge i_mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (k = 0; k < `TBL_ENTRIES; k = k + 1) begin
                user_table[k] <= `TBL_ALL_LOW;
            end
        end else if (i_user_table_wr) begin
            user_table[i_user_table_addr] <= i_user_table_data;
        end
    end

    // pattern select and output multiplexer
    always @* begin
        if (i_user_table_en) begin
            pattern = user_table[{i_rotation_direction, hall_code}];
        end else begin
            pattern = default_pattern(i_rotation_direction, hall_code);
        end
        next_gate[5] = resolve(pattern[11:10], o_pwm);
        next_gate[4] = resolve(pattern[9:8], o_pwm);
        next_gate[3] = resolve(pattern[7:6], o_pwm);
        next_gate[2] = resolve(pattern[5:4], o_pwm);
        next_gate[1] = resolve(pattern[3:2], o_pwm);
        next_gate[0] = resolve(pattern[1:0], o_pwm);
        if (i_sine_select) begin
            next_gate = i_sine_gates;
        end
    end

    // registered outputs: carrier, compare, gates
    always @(posedge i_mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            o_carrier <= `CNT_ZERO;
            o_pwm     <= 1'b0;
            o_gate_u  <= 1'b0;
            o_gate_v  <= 1'b0;
            o_gate_w  <= 1'b0;
            o_gate_x  <= 1'b0;
            o_gate_y  <= 1'b0;
            o_gate_z  <= 1'b0;
        end else begin
            o_carrier <= carrier;
            o_pwm     <= (carrier < duty);
            o_gate_u  <= next_gate[5];
            o_gate_v  <= next_gate[4];
            o_gate_w  <= next_gate[3];
            o_gate_x  <= next_gate[2];
            o_gate_y  <= next_gate[1];
            o_gate_z  <= next_gate[0];
        end
    end

endmodule
`default_nettype wire

// File: dv/hall_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module hall_sensor_model (
    input  wire logic [2:0] i_code, // rotor sector code
    output var  logic [2:0] o_hall  // sensor outputs
);
    // edges land off the clock grid, as from a real rotor
    always @(i_code) o_hall <= #1.3 i_code;
    initial o_hall = 3'h0;
endmodule
`default_nettype wire

// File: dv/motor_pwm_engine_chk.sv
`timescale 1ns/1ps
`default_nettype none
module motor_pwm_engine_chk (
    input wire logic        i_mclk,                 // clock
    input wire logic        i_arst_n,               // reset
    input wire logic [1:0]  i_carrier_shape_select, // shape
    input wire logic [1:0]  i_carrier_prescale,     // prescale
    input wire logic [2:0]  i_carrier_postscale,    // postscale
    input wire logic [10:0] i_carrier_period,       // period
    input wire logic [7:0]  i_duty_high_reg,        // duty high
    input wire logic [2:0]  i_duty_low_ext_reg,     // duty low
    input wire logic [2:0]  i_hall_soft,            // soft hall
    input wire logic        i_hall_pin_mode,        // pin source
    input wire logic        i_rotation_direction,   // direction
    input wire logic        i_user_table_en,        // user table
    input wire logic        i_sine_select,          // sine path
    input wire logic [5:0]  i_sine_gates,           // sine gates
    input wire logic [10:0] o_carrier,              // carrier
    input wire logic        o_pwm,                  // pwm
    input wire logic        o_gate_u,               // gate u
    input wire logic        o_gate_v,               // gate v
    input wire logic        o_gate_w,               // gate w
    input wire logic        o_gate_x,               // gate x
    input wire logic        o_gate_y,               // gate y
    input wire logic        o_gate_z                // gate z
);
    logic [2:0]  run;   // edges since release
    logic [5:0]  age;   // cycles since carrier settings changed
    logic [17:0] cfg_q; // last carrier settings
    wire  [17:0] cfg = {i_carrier_shape_select, i_carrier_prescale, i_carrier_postscale,
                        i_carrier_period};
    wire  [5:0]  g   = {o_gate_u, o_gate_v, o_gate_w, o_gate_x, o_gate_y, o_gate_z};
    wire         ok  = (run == 3'h7);                  // sync reset long gone
    wire         st  = ok && (age == 6'h3f);           // settings past any tick
    wire         sw  = ok && !i_sine_select && !i_hall_pin_mode && !i_user_table_en;
    // warm-up and settling counters
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run   <= 3'h0;
            age   <= 6'h00;
            cfg_q <= 18'h00000;
        end else begin
            run   <= (run == 3'h7) ? run : run + 3'h1;
            cfg_q <= cfg;
            age   <= (cfg != cfg_q) ? 6'h00 : ((age == 6'h3f) ? age : age + 6'h01);
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    sine_pass_a: assert property (ok && i_sine_select |=> g == $past(i_sine_gates))
        else $error("gates do not follow sine path");
    bad_hall_a: assert property (sw && (i_hall_soft == 3'h0 || i_hall_soft == 3'h7) |=> g == 6'h00)
        else $error("invalid hall code drives a gate");
    fwd_pattern_a: assert property (sw && !i_rotation_direction && i_hall_soft == 3'h1
        |=> o_gate_y && (o_gate_x != o_gate_u) && !(o_gate_v || o_gate_w || o_gate_z))
        else $error("direction zero pattern wrong");
    rev_pattern_a: assert property (sw && i_rotation_direction && i_hall_soft == 3'h5
        |=> o_gate_x && (o_gate_z != o_gate_w) && !(o_gate_u || o_gate_v || o_gate_y))
        else $error("direction one pattern wrong");
    pwm_cmp_a: assert property (ok && $stable({i_duty_high_reg, i_duty_low_ext_reg})
        |-> o_pwm == (o_carrier < {i_duty_high_reg, i_duty_low_ext_reg}))
        else $error("pwm compare wrong");
    up_step_a: assert property (st && i_carrier_shape_select == 2'h0 && $changed(o_carrier)
        |-> o_carrier == $past(o_carrier) + 11'h001 || o_carrier == 11'h000)
        else $error("up carrier step wrong");
    down_step_a: assert property (st && i_carrier_shape_select == 2'h1 && $changed(o_carrier)
        |-> o_carrier == $past(o_carrier) - 11'h001 || o_carrier == i_carrier_period - 11'h001)
        else $error("down carrier step wrong");
    tick_hold_a: assert property (st && (i_carrier_prescale > 2'h1 || i_carrier_postscale > 3'h1)
        && $changed(o_carrier) |=> $stable(o_carrier))
        else $error("carrier moved between ticks");
endmodule
bind motor_pwm_engine motor_pwm_engine_chk u_chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_carrier_shape_select(i_carrier_shape_select), .i_carrier_prescale(i_carrier_prescale),
    .i_carrier_postscale(i_carrier_postscale), .i_carrier_period(i_carrier_period),
    .i_duty_high_reg(i_duty_high_reg), .i_duty_low_ext_reg(i_duty_low_ext_reg),
    .i_hall_soft(i_hall_soft), .i_hall_pin_mode(i_hall_pin_mode),
    .i_rotation_direction(i_rotation_direction), .i_user_table_en(i_user_table_en),
    .i_sine_select(i_sine_select), .i_sine_gates(i_sine_gates), .o_carrier(o_carrier),
    .o_pwm(o_pwm), .o_gate_u(o_gate_u), .o_gate_v(o_gate_v), .o_gate_w(o_gate_w),
    .o_gate_x(o_gate_x), .o_gate_y(o_gate_y), .o_gate_z(o_gate_z));
`default_nettype wire

// File: dv/motor_pwm_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
module motor_pwm_engine_tb;
    logic        clk = 1'b0, rst_n = 1'b1;         // clock, reset
    logic [1:0]  shp = '0, pre = '0;               // shape, prescale
    logic [2:0]  post = '0, hs = '0, hc = '0;      // postscale, soft and rotor hall
    logic [10:0] per = '0, duty = '0, mx;          // period, duty, carrier peak
    logic        pm = 0, dir = 0, uen = 0, uwr = 0, ssel = 0; // mode bits
    logic [3:0]  ua = '0;                          // table address
    logic [11:0] ud = '0;                          // table data
    logic [5:0]  sg = '0;                          // sine gates
    logic [11:0] ut [16];                          // expected user table
    wire  [2:0]  hp;                               // hall pins
    wire  [10:0] car;                              // carrier
    wire  [5:0]  g;                                // gates u..z
    wire         pwm;                              // compare out
    int          miscompares = 0, cmp_count = 0, n, r;
    motor_pwm_engine u_dut (.i_mclk(clk), .i_arst_n(rst_n), .i_carrier_shape_select(shp),
        .i_carrier_prescale(pre), .i_carrier_postscale(post), .i_carrier_period(per),
        .i_duty_high_reg(duty[10:3]), .i_duty_low_ext_reg(duty[2:0]), .i_hall_pins(hp),
        .i_hall_soft(hs), .i_hall_pin_mode(pm), .i_rotation_direction(dir),
        .i_user_table_en(uen), .i_user_table_wr(uwr), .i_user_table_addr(ua),
        .i_user_table_data(ud), .i_sine_select(ssel), .i_sine_gates(sg), .o_carrier(car),
        .o_pwm(pwm), .o_gate_u(g[5]), .o_gate_v(g[4]), .o_gate_w(g[3]), .o_gate_x(g[2]),
        .o_gate_y(g[1]), .o_gate_z(g[0]));
    hall_sensor_model u_hall (.i_code(hc), .o_hall(hp));
    initial forever #2 clk = ~clk;
    // default drive codes {u,v,w,x,y,z}: 0 low, 1 high, 2 pwm, 3 inverse
    function automatic logic [11:0] dflt(input logic d, input logic [2:0] h);
        case ({d, h})
            4'h1, 4'he: return 12'h834;
            4'h3, 4'hc: return 12'h087;
            4'h2, 4'hd: return 12'h093;
            4'h6, 4'h9: return 12'h21c;
            4'h4, 4'hb: return 12'h20d;
            4'h5, 4'ha: return 12'h831;
            default:    return 12'h000;
        endcase
    endfunction
    // gate levels from drive codes and the compare level
    function automatic logic [5:0] gexp(input logic [11:0] c, input logic p);
        for (int i = 0; i < 6; i++)
            gexp[5-i] = (c[11-2*i -: 2] == 2'h1) || (c[11-2*i -: 2] == {1'b1, !p});
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // waits for the carrier to return to zero, counting cycles and peak
    task automatic zwait();
        logic [10:0] pv;
        mx = '0;
        pv = car;
        for (n = 1; n < 4000; n++) begin
            @(negedge clk);
            chk({11'h000, pwm}, {11'h000, car < duty}, "pwm level");
            if (car > mx) mx = car;
            if (pv != 0 && car == 0) break;
            pv = car;
        end
        if (n == 4000) begin
            miscompares++;
            $display("[ERR] %0t carrier never wrapped", $time);
            tally_and_finish();
        end
    endtask
    task automatic carrier(input logic [1:0] s, input logic [1:0] a, input logic [2:0] b,
                           input logic [10:0] p);
        int k;
        per = '0; // park at zero so the new period starts clean
        duty = 11'($urandom_range(22, 0)); // compare level spread over the carrier range
        repeat (25) @(negedge clk);
        chk({1'b0, car}, 12'h000, "parked carrier");
        shp = s; pre = a; post = b; per = p;
        k = (a == 0 ? 1 : a) * (b == 0 ? 1 : b) * p * (s[1] ? 2 : 1);
        zwait(); zwait(); zwait();
        chk(12'(n), 12'(k), "carrier length");
        chk({1'b0, mx}, {1'b0, s[1] ? p : p - 11'h001}, "carrier peak");
    endtask
    task automatic commute(input logic d, input logic [2:0] h, input logic [10:0] du);
        // the unused hall source carries the inverse code, so a wrong source shows
        dir = d;
        hs = pm ? ~h : h;
        hc = pm ? h : ~h;
        duty = du;
        repeat (5) @(negedge clk);
        chk({6'h00, g}, {6'h00, gexp(uen ? ut[{d, h}] : dflt(d, h), du != 0)}, "gates");
    endtask
    initial begin
        r = $urandom(35132);
        #1 rst_n = 0;
        repeat (4) @(negedge clk);
        rst_n = 1;
        repeat (4) @(negedge clk);
        carrier(2'h0, 2'h0, 3'h0, 11'h002);
        carrier(2'h3, 2'h3, 3'h7, 11'h014);
        for (int i = 0; i < 24; i++)
            carrier(2'(i % 4), 2'($urandom), 3'($urandom), 11'($urandom_range(20, 2)));
        carrier(2'h0, 2'h1, 3'h1, 11'h00a);
        for (int i = 0; i < 16; i++) begin
            ut[i] = 12'($urandom);
            uwr = 1; ua = 4'(i); ud = ut[i];
            @(negedge clk);
        end
        uwr = 0;
        // soft default, pin default, then user table
        for (int m = 0; m < 3; m++) begin
            pm = (m == 1); uen = (m == 2);
            for (int i = 0; i < 32; i++)
                commute(i[4], 3'(i), i[3] ? 11'h7ff : 11'h000);
        end
        ssel = 1;
        for (int i = 0; i < 8; i++) begin
            sg = 6'($urandom);
            repeat (2) @(negedge clk);
            chk({6'h00, g}, {6'h00, sg}, "sine gates");
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
